// ### design/fcdma_top.sv
// Purpose: four-channel DMA unit with two channel modules, inter-module arbiter and pointers
// Assumes: inputs synchronous to clk_sys; the bus unit answers a request with busDone
// Notes: a transfer is one fetch then one deposit; the bus is released after each deposit
`include "fcdma_defs.svh"
`default_nettype none
module fcdma_top
  import fcdma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [5:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  input wire logic ext_request_pin_0,
  input wire logic ext_request_pin_1,
  input wire logic ext_request_pin_2,
  input wire logic ext_request_pin_3,
  input wire logic serial0_transmit_request,
  input wire logic serial0_receive_request,
  input wire logic serial1_transmit_request,
  input wire logic serial1_receive_request,
  input wire logic second_timer_request,
  output logic busReq,
  input wire logic busDone,
  input wire logic [15:0] busRdata,
  output logic [19:0] busAddr,
  output logic busIsMem,
  output logic busIsWrite,
  output logic busWord,
  output logic [15:0] busWdata,
  output logic [1:0] busChannel
);
  fcdma_state_e stateReg;
  fcdma_state_e stateNext;
  logic [1:0] chanReg;
  logic [1:0] chanNext;
  fcdma_ptr_t busAddrReg;
  fcdma_ptr_t busAddrNext;
  logic busIsMemReg;
  logic busIsMemNext;
  fcdma_ptr_t srcPtrReg [4];
  fcdma_ptr_t srcPtrNext [4];
  fcdma_ptr_t dstPtrReg [4];
  fcdma_ptr_t dstPtrNext [4];
  fcdma_word_t ctrlReg [4];
  fcdma_word_t ctrlNext [4];
  fcdma_word_t prioReg;
  fcdma_word_t prioNext;
  fcdma_word_t rdataReg;
  fcdma_word_t rdataNext;
  logic [3:0] chanReq;
  logic [3:0] extPins;
  logic [3:0] serialReq;
  logic reqA;
  logic reqB;
  logic winA;
  logic winB;
  logic winMod;
  logic [1:0] grantChan;
  logic fetchDone;
  logic depositDone;
  logic bufInReady;
  logic bufOutValid;
  fcdma_ptr_t grantSrc;
  fcdma_ptr_t curSrc;
  fcdma_ptr_t curDst;
  fcdma_word_t curCtrl;
  fcdma_ptr_t curStep;

  // Next pointer value after one transfer
  function automatic fcdma_ptr_t indexPtr(input fcdma_ptr_t ptr, input logic inc, input logic dec,
                                          input logic word);
    fcdma_ptr_t step;
    step = word ? `FCDMA_STEP_WORD : `FCDMA_STEP_BYTE;
    if (inc && !dec)
      return ptr + step;
    else if (dec && !inc)
      return ptr - step;
    else
      return ptr;
  endfunction

  // True when the address selects register sel of channel ch
  function automatic logic isChanReg(input logic [5:0] addr, input logic [1:0] ch, input logic [2:0] sel);
    return !addr[`FCDMA_ADDR_SHARED] && (addr[4:3] == ch) && (addr[2:0] == sel);
  endfunction

  assign extPins = {ext_request_pin_3, ext_request_pin_2, ext_request_pin_1, ext_request_pin_0};
  assign serialReq = {serial1_receive_request, serial1_transmit_request,
                      serial0_receive_request, serial0_transmit_request};

  // Channel 0 of a module takes transmit, channel 1 receive, unless the module selects the timer
  generate
    for (genvar g = 0; g < 4; g++)
    begin : gen_req
      logic internalReq;
      assign internalReq = prioReg[`FCDMA_PRIO_TMR_A + g / 2] ? second_timer_request : serialReq[g];
      assign chanReq[g] = ctrlReg[g][`FCDMA_CTRL_STRT] &
                          (ctrlReg[g][`FCDMA_CTRL_IDRQ] ? internalReq : extPins[g]);
    end
  endgenerate

  // Identical channel arbiters for modules A and B
  fcdma_arb2 u_arb_a
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .req(chanReq[1:0]),
    .prioHigh({ctrlReg[1][`FCDMA_CTRL_PRIO], ctrlReg[0][`FCDMA_CTRL_PRIO]}),
    .doneValid(depositDone && !chanReg[1]),
    .doneChan(chanReg[0]),
    .anyReq(reqA),
    .winChan(winA)
  );

  fcdma_arb2 u_arb_b
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .req(chanReq[3:2]),
    .prioHigh({ctrlReg[3][`FCDMA_CTRL_PRIO], ctrlReg[2][`FCDMA_CTRL_PRIO]}),
    .doneValid(depositDone && chanReg[1]),
    .doneChan(chanReg[0]),
    .anyReq(reqB),
    .winChan(winB)
  );

  // Inter-module arbiter: requester 1 is module B, high after reset
  fcdma_arb2 u_arb_mod
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .req({reqB, reqA}),
    .prioHigh({prioReg[`FCDMA_PRIO_B_HIGH], prioReg[`FCDMA_PRIO_A_HIGH]}),
    .doneValid(depositDone),
    .doneChan(chanReg[1]),
    .anyReq(),
    .winChan(winMod)
  );

  assign grantChan = winMod ? {1'h1, winB} : {1'h0, winA};

  fcdma_buf2 u_buf
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .inValid(fetchDone),
    .inReady(bufInReady),
    .inData(busRdata),
    .outValid(bufOutValid),
    .outReady(depositDone),
    .outData(busWdata)
  );

  assign grantSrc = srcPtrReg[grantChan];
  assign curSrc = srcPtrReg[chanReg];
  assign curDst = dstPtrReg[chanReg];
  assign curCtrl = ctrlReg[chanReg];
  assign curStep = curCtrl[`FCDMA_CTRL_WORD] ? `FCDMA_STEP_WORD : `FCDMA_STEP_BYTE;

  // A full buffer stalls the fetch; an empty one stalls the deposit
  assign busReq = ((stateReg == ST_FETCH) && bufInReady) || ((stateReg == ST_DEPOSIT) && bufOutValid);
  assign fetchDone = (stateReg == ST_FETCH) && busReq && busDone;
  assign depositDone = (stateReg == ST_DEPOSIT) && busReq && busDone;
  assign busAddr = busAddrReg;
  assign busIsMem = busIsMemReg;
  assign busIsWrite = (stateReg == ST_DEPOSIT);
  assign busWord = curCtrl[`FCDMA_CTRL_WORD];
  assign busChannel = chanReg;
  assign regRdata = rdataReg;

  // Transfer sequencer
  always_comb
  begin
    stateNext = stateReg;
    chanNext = chanReg;
    busAddrNext = busAddrReg;
    busIsMemNext = busIsMemReg;
    case (stateReg)
      ST_IDLE:
        if ((reqA || reqB) && !prioReg[`FCDMA_PRIO_SUSP])
        begin
          stateNext = ST_FETCH;
          chanNext = grantChan;
          busAddrNext = grantSrc;
          busIsMemNext = ctrlReg[grantChan][`FCDMA_CTRL_SOURCE_SPACE_SELECT];
        end
      ST_FETCH:
        if (fetchDone)
        begin
          stateNext = ST_DEPOSIT;
          busAddrNext = curDst;
          busIsMemNext = curCtrl[`FCDMA_CTRL_DEST_SPACE_SELECT];
        end
      ST_DEPOSIT:
        if (depositDone)
          stateNext = ST_IDLE;
      default:
        stateNext = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      stateReg <= ST_IDLE;
      chanReg <= 2'h0;
      busAddrReg <= `FCDMA_PTR_RESET;
      busIsMemReg <= 1'h0;
    end
    else if (clkEnable)
    begin
      stateReg <= stateNext;
      chanReg <= chanNext;
      busAddrReg <= busAddrNext;
      busIsMemReg <= busIsMemNext;
    end
  end

  // Register file; a software write to a pointer half beats the indexing in the same cycle
  always_comb
  begin
    prioNext = prioReg;
    rdataNext = rdataReg;
    for (int c = 0; c < 4; c++)
    begin
      srcPtrNext[c] = srcPtrReg[c];
      dstPtrNext[c] = dstPtrReg[c];
      ctrlNext[c] = ctrlReg[c];
      if (fetchDone && chanReg == 2'(c))
        srcPtrNext[c] = indexPtr(srcPtrReg[c], ctrlReg[c][`FCDMA_CTRL_SINC], ctrlReg[c][`FCDMA_CTRL_SDEC],
                                 ctrlReg[c][`FCDMA_CTRL_WORD]);
      if (depositDone && chanReg == 2'(c))
        dstPtrNext[c] = indexPtr(dstPtrReg[c], ctrlReg[c][`FCDMA_CTRL_DINC], ctrlReg[c][`FCDMA_CTRL_DDEC],
                                 ctrlReg[c][`FCDMA_CTRL_WORD]);
      if (regWrite)
      begin
        if (isChanReg(regAddr, 2'(c), `FCDMA_REG_SRC_LO))
          srcPtrNext[c][15:0] = regWdata;
        if (isChanReg(regAddr, 2'(c), `FCDMA_REG_SRC_HI))
          srcPtrNext[c][19:16] = regWdata[3:0];
        if (isChanReg(regAddr, 2'(c), `FCDMA_REG_DST_LO))
          dstPtrNext[c][15:0] = regWdata;
        if (isChanReg(regAddr, 2'(c), `FCDMA_REG_DST_HI))
          dstPtrNext[c][19:16] = regWdata[3:0];
        if (isChanReg(regAddr, 2'(c), `FCDMA_REG_CTRL))
        begin
          ctrlNext[c] = regWdata & `FCDMA_CTRL_MASK;
          if (!regWdata[`FCDMA_CTRL_CHG])
            ctrlNext[c][`FCDMA_CTRL_STRT] = ctrlReg[c][`FCDMA_CTRL_STRT];
        end
      end
    end
    if (regWrite && regAddr == `FCDMA_REG_PRIO)
      prioNext = regWdata & `FCDMA_PRIO_MASK;
    if (regRead)
    begin
      rdataNext = `FCDMA_RD_UNMAPPED;
      if (regAddr == `FCDMA_REG_PRIO)
        rdataNext = prioReg;
      else if (regAddr == `FCDMA_REG_STAT)
        rdataNext = {`FCDMA_STAT_PAD, chanReg, stateReg, busReq};
      else if (!regAddr[`FCDMA_ADDR_SHARED])
        case (regAddr[2:0])
          `FCDMA_REG_SRC_LO: rdataNext = srcPtrReg[regAddr[4:3]][15:0];
          `FCDMA_REG_SRC_HI: rdataNext = {`FCDMA_UPPER_PAD, srcPtrReg[regAddr[4:3]][19:16]};
          `FCDMA_REG_DST_LO: rdataNext = dstPtrReg[regAddr[4:3]][15:0];
          `FCDMA_REG_DST_HI: rdataNext = {`FCDMA_UPPER_PAD, dstPtrReg[regAddr[4:3]][19:16]};
          `FCDMA_REG_CTRL: rdataNext = ctrlReg[regAddr[4:3]];
          default: rdataNext = `FCDMA_RD_UNMAPPED;
        endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      for (int c = 0; c < 4; c++)
      begin
        srcPtrReg[c] <= `FCDMA_PTR_RESET;
        dstPtrReg[c] <= `FCDMA_PTR_RESET;
        ctrlReg[c] <= `FCDMA_CTRL_RESET;
      end
      prioReg <= `FCDMA_PRIO_RESET;
      rdataReg <= `FCDMA_RDATA_RESET;
    end
    else if (clkEnable)
    begin
      srcPtrReg <= srcPtrNext;
      dstPtrReg <= dstPtrNext;
      ctrlReg <= ctrlNext;
      prioReg <= prioNext;
      rdataReg <= rdataNext;
    end
  end

  a_fetch_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (stateReg == ST_IDLE && stateNext == ST_FETCH && clkEnable) |=>
      (busAddr == $past(grantSrc) && busReq == bufInReady && !busIsWrite))
    else $error("fetch address is not the granted source pointer");

  a_deposit_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (fetchDone && clkEnable) |=> (busAddr == $past(curDst) && busIsWrite &&
      busIsMem == $past(curCtrl[`FCDMA_CTRL_DEST_SPACE_SELECT])))
    else $error("deposit address or space is wrong");

  a_src_index: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (fetchDone && clkEnable && !regWrite && curCtrl[`FCDMA_CTRL_SINC] && !curCtrl[`FCDMA_CTRL_SDEC]) |=>
      (curSrc == $past(curSrc) + $past(curStep)))
    else $error("source pointer not advanced by the data width");

  a_ptr_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (depositDone && clkEnable && !regWrite && curCtrl[`FCDMA_CTRL_DINC] == curCtrl[`FCDMA_CTRL_DDEC]) |=>
      (curDst == $past(curDst)))
    else $error("destination pointer moved with equal index bits");

  a_mod_grant: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (stateReg == ST_IDLE && clkEnable && reqA && reqB && !prioReg[`FCDMA_PRIO_SUSP] &&
      prioReg[`FCDMA_PRIO_A_HIGH] && !prioReg[`FCDMA_PRIO_B_HIGH]) |=> (stateReg == ST_FETCH && !chanReg[1]))
    else $error("higher priority module A did not win the bus");

  a_suspend_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (stateReg == ST_IDLE && prioReg[`FCDMA_PRIO_SUSP] && !regWrite) |=> (stateReg == ST_IDLE))
    else $error("transfer started while suspended");
endmodule
`default_nettype wire

// ### design/fcdma_defs.svh
// Purpose: named offsets, field positions, reset values and steps of the DMA unit
// Assumes: included by the design module files of the unit
// Notes: definitions only
`ifndef FCDMA_DEFS_SVH
`define FCDMA_DEFS_SVH
`define FCDMA_ADDR_SHARED 5
`define FCDMA_REG_SRC_LO 3'h0
`define FCDMA_REG_SRC_HI 3'h1
`define FCDMA_REG_DST_LO 3'h2
`define FCDMA_REG_DST_HI 3'h3
`define FCDMA_REG_CTRL 3'h4
`define FCDMA_REG_PRIO 6'h20
`define FCDMA_REG_STAT 6'h21
`define FCDMA_CTRL_DEST_SPACE_SELECT 15
`define FCDMA_CTRL_DDEC 14
`define FCDMA_CTRL_DINC 13
`define FCDMA_CTRL_SOURCE_SPACE_SELECT 12
`define FCDMA_CTRL_SDEC 11
`define FCDMA_CTRL_SINC 10
`define FCDMA_CTRL_PRIO 5
`define FCDMA_CTRL_IDRQ 4
`define FCDMA_CTRL_CHG 2
`define FCDMA_CTRL_STRT 1
`define FCDMA_CTRL_WORD 0
`define FCDMA_CTRL_MASK 16'hfc33
`define FCDMA_PRIO_A_HIGH 0
`define FCDMA_PRIO_B_HIGH 1
`define FCDMA_PRIO_TMR_A 2
`define FCDMA_PRIO_SUSP 4
`define FCDMA_PRIO_MASK 16'h001f
`define FCDMA_CTRL_RESET 16'h0000
`define FCDMA_PRIO_RESET 16'h0000
`define FCDMA_RDATA_RESET 16'h0000
`define FCDMA_RD_UNMAPPED 16'h0000
`define FCDMA_UPPER_PAD 12'h000
`define FCDMA_STAT_PAD 11'h000
`define FCDMA_PTR_RESET 20'h00000
`define FCDMA_STEP_BYTE 20'h00001
`define FCDMA_STEP_WORD 20'h00002
`define FCDMA_ROT_RESET 1'h1
`define FCDMA_BUF_DEPTH 2'h2
`define FCDMA_BUF_EMPTY 2'h0
`endif

// ### design/fcdma_pkg.sv
// Purpose: shared types of the DMA unit
// Assumes: nothing
// Notes: constants live in fcdma_defs.svh
`default_nettype none
package fcdma_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_DEPOSIT = 2'b10} fcdma_state_e;
  typedef logic [19:0] fcdma_ptr_t;
  typedef logic [15:0] fcdma_word_t;
endpackage
`default_nettype wire

// ### design/fcdma_arb2.sv
// Purpose: two-way arbiter with fixed or rotating priority
// Assumes: doneValid pulses once per completed transfer of one of the two requesters
// Notes: serves as channel arbiter of a module and as inter-module arbiter
`include "fcdma_defs.svh"
`default_nettype none
module fcdma_arb2
  import fcdma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic [1:0] req,
  input wire logic [1:0] prioHigh,
  input wire logic doneValid,
  input wire logic doneChan,
  output logic anyReq,
  output logic winChan
);
  logic highOneReg;
  logic highOneNext;
  logic equalPrio;

  assign equalPrio = (prioHigh[0] == prioHigh[1]);
  assign anyReq = |req;

  always_comb
  begin
    if (req == 2'h3)
      winChan = equalPrio ? highOneReg : prioHigh[1];
    else
      winChan = req[1];
  end

  always_comb
  begin
    highOneNext = highOneReg;
    if (doneValid && equalPrio)
      highOneNext = ~doneChan;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      highOneReg <= `FCDMA_ROT_RESET;
    else if (clkEnable)
      highOneReg <= highOneNext;
  end

  a_fixed_winner: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (req == 2'h3 && prioHigh == 2'h1) |-> !winChan)
    else $error("fixed priority did not pick the high requester");

  a_rotate_demote: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clkEnable && doneValid && equalPrio) ##1 (req == 2'h3 && equalPrio) |-> (winChan != $past(doneChan)))
    else $error("last served requester kept high rotating priority");

  a_reset_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!$past(reset_n)) |-> (highOneReg && (req != 2'h3 || !equalPrio || winChan)))
    else $error("requester 1 not high after reset");
endmodule
`default_nettype wire

// ### design/fcdma_buf2.sv
// Purpose: two-entry buffer between fetched and deposited data
// Assumes: one clock, synchronous reset
// Notes: inReady falls when both entries hold data
`include "fcdma_defs.svh"
`default_nettype none
module fcdma_buf2
  import fcdma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic inValid,
  output logic inReady,
  input wire fcdma_word_t inData,
  output logic outValid,
  input wire logic outReady,
  output fcdma_word_t outData
);
  fcdma_word_t entryReg [2];
  fcdma_word_t entryNext [2];
  logic wrPtrReg;
  logic wrPtrNext;
  logic rdPtrReg;
  logic rdPtrNext;
  logic [1:0] countReg;
  logic [1:0] countNext;
  logic push;
  logic pop;

  assign inReady = (countReg != `FCDMA_BUF_DEPTH);
  assign outValid = (countReg != `FCDMA_BUF_EMPTY);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = entryReg[rdPtrReg];

  always_comb
  begin
    entryNext[0] = entryReg[0];
    entryNext[1] = entryReg[1];
    if (push)
      entryNext[wrPtrReg] = inData;
    wrPtrNext = wrPtrReg ^ push;
    rdPtrNext = rdPtrReg ^ pop;
    countNext = countReg + {1'h0, push} - {1'h0, pop};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      entryReg[0] <= `FCDMA_RDATA_RESET;
      entryReg[1] <= `FCDMA_RDATA_RESET;
      wrPtrReg <= 1'h0;
      rdPtrReg <= 1'h0;
      countReg <= `FCDMA_BUF_EMPTY;
    end
    else if (clkEnable)
    begin
      entryReg <= entryNext;
      wrPtrReg <= wrPtrNext;
      rdPtrReg <= rdPtrNext;
      countReg <= countNext;
    end
  end
endmodule
`default_nettype wire

// ### dv/fcdma_biu_model.sv
// Purpose: bus unit model that runs the fetch and deposit cycles of the DMA unit
// Assumes: busReq is a level held until busDone is taken
// Notes: waitCycles sets the answer delay; read data changes every cycle outside an answer
`default_nettype none
module fcdma_biu_model
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic busReq,
  input wire logic busIsWrite,
  input wire logic [19:0] busAddr,
  input wire logic [1:0] waitCycles,
  output logic busDone,
  output logic [15:0] busRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] waitCount;
  always @(posedge clk_sys)
  begin
    if (!reset_n || !busReq || busDone)
    begin
      busDone <= 1'h0;
      waitCount <= 2'h0;
      busRdata <= reset_n ? ~busRdata : 16'ha5a5;
    end
    else if (waitCount >= waitCycles)
    begin
      busDone <= 1'h1;
      busRdata <= busIsWrite ? ~busRdata : busAddr[15:0] ^ 16'h5a5a;
    end
    else
    begin
      waitCount <= waitCount + 2'h1;
      busRdata <= ~busRdata;
    end
  end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Purpose: self-checking bench of the four-channel DMA unit
// Assumes: fcdma_biu_model stands for the bus unit
// Notes: an integer model tracks registers, pointers and both arbitration levels
`include "fcdma_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic clkEnable = 1'h1;
  logic regWrite = 1'h0;
  logic regRead = 1'h0;
  logic jitter = 1'h0;
  logic [5:0] regAddr = 6'h00;
  logic [15:0] regWdata = 16'h0000;
  logic [3:0] pin = 4'h0;
  logic [4:0] inner = 5'h00;
  logic [1:0] waitCycles = 2'h0;
  logic [15:0] regRdata, busRdata, busWdata;
  logic [19:0] busAddr;
  logic [1:0] busChannel;
  logic busReq, busDone, busIsMem, busIsWrite, busWord;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int srcP[4], dstP[4], ctl[4];
  int prioReg = 0;
  int rotMod = 1;
  int rotCh[2] = '{1, 1};
  int expWin = -1;
  int lastData = 0;
  int lastCh = 0;
  int fetched[$];
  int ch;
  fcdma_top fcdma_top_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clkEnable(clkEnable), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .ext_request_pin_0(pin[0]),
    .ext_request_pin_1(pin[1]), .ext_request_pin_2(pin[2]), .ext_request_pin_3(pin[3]),
    .serial0_transmit_request(inner[0]), .serial0_receive_request(inner[1]), .serial1_transmit_request(inner[2]),
    .serial1_receive_request(inner[3]), .second_timer_request(inner[4]), .busReq(busReq), .busDone(busDone),
    .busRdata(busRdata), .busAddr(busAddr), .busIsMem(busIsMem), .busIsWrite(busIsWrite), .busWord(busWord),
    .busWdata(busWdata), .busChannel(busChannel));
  fcdma_biu_model fcdma_biu_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .busReq(busReq),
    .busIsWrite(busIsWrite), .busAddr(busAddr), .waitCycles(waitCycles), .busDone(busDone), .busRdata(busRdata));
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    clkEnable <= jitter ? ($urandom % 8 != 0) : 1'h1;
    if (cycles == 30000)
    begin
      bad_count++;
      complete_run();
    end
  end
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge clk_sys);
    regWrite <= 1'h0;
  endtask
  task automatic rdchk(input logic [5:0] a, input int exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk_sys);
    regRead <= 1'h0;
    @(posedge clk_sys);
    check(regRdata, exp[15:0]);
  endtask
  // Winner of a two-way contest: lone requester, else fixed high, else rotation
  function automatic int pick(input int rq, input int ph, input int rot);
    if (rq != 3)
      return rq >> 1;
    if (ph == 1 || ph == 2)
      return ph >> 1;
    return rot;
  endfunction
  function automatic int step(input int p, input int bits, input int word);
    if ((bits & 1) == ((bits >> 1) & 1))
      return p;
    return (p + ((bits & 1) ? 1 : -1) * (word ? 2 : 1)) & 20'hfffff;
  endfunction
  function automatic int expWinner();
    int r[4];
    int m;
    if (prioReg[4])
      return -1;
    for (int c = 0; c < 4; c++)
      r[c] = ctl[c][1] && (ctl[c][4] ? (prioReg[2 + c / 2] ? inner[4] : inner[c]) : pin[c]);
    m = r[0] | r[1] | 2 * (r[2] | r[3]);
    if (m == 0)
      return -1;
    m = pick(m, prioReg & 3, rotMod);
    return 2 * m + pick(r[2 * m] + 2 * r[2 * m + 1], ctl[2 * m][5] + 2 * ctl[2 * m + 1][5], rotCh[m]);
  endfunction
  // Grant is taken in an idle cycle; fetch and deposit are checked where busDone is taken
  always @(posedge clk_sys)
  begin
    ch = expWin & 3;
    if (reset_n && clkEnable && !busReq)
      expWin = expWinner();
    else if (reset_n && clkEnable && busDone && !busIsWrite)
    begin
      check(busChannel, expWin);
      check(busAddr, srcP[ch]);
      check({busIsMem, busWord}, ctl[ch][12] * 2 + ctl[ch][0]);
      fetched.push_back(busRdata);
      lastCh = ch;
      srcP[ch] = step(srcP[ch], ctl[ch] >> 10, ctl[ch][0]);
    end
    else if (reset_n && clkEnable && busDone)
    begin
      check(busAddr, dstP[ch]);
      // A deposit with no fetched word left can never match
      lastData = 32'h7ffff;
      if (fetched.size() > 0)
        lastData = fetched.pop_front();
      check({busIsMem, busWdata}, ctl[ch][15] * 65536 + lastData);
      dstP[ch] = step(dstP[ch], ctl[ch] >> 13, ctl[ch][0]);
      if (ctl[ch & 2][5] == ctl[ch | 1][5])
        rotCh[ch / 2] = 1 - ch % 2;
      if (prioReg % 4 == 0 || prioReg % 4 == 3)
        rotMod = 1 - ch / 2;
    end
  end
  initial
  begin
    int d;
    d = $urandom(32'h21a1);
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'h1;
    rdchk(6'h3f, 0);
    for (int r = 0; r < 24; r++)
    begin
      jitter <= 1'h0;
      pin <= 4'h0;
      inner <= 5'h00;
      repeat (40) @(posedge clk_sys);
      rdchk(6'h21, lastCh * 8);
      rdchk(6'h20, prioReg);
      for (int c = 0; c < 4; c++)
      begin
        rdchk(6'(c * 8), srcP[c] & 16'hffff);
        rdchk(6'(c * 8 + 1), srcP[c] >> 16);
        rdchk(6'(c * 8 + 2), dstP[c] & 16'hffff);
        rdchk(6'(c * 8 + 3), dstP[c] >> 16);
        rdchk(6'(c * 8 + 4), ctl[c]);
        rdchk(6'(c * 8 + 5), 0);
        d = $urandom % 65536;
        ctl[c] = (d & `FCDMA_CTRL_MASK & 16'hfffd) | (d[2] ? d & 2 : ctl[c] & 2);
        srcP[c] = r % 2 ? 20'h0ffff + ($urandom % 16) * 65536 : $urandom % 1048576;
        dstP[c] = r % 4 == 2 ? 20'h10000 : $urandom % 1048576;
        // Every third round, I/O-space sources keep the upper source pointer bits clear
        if (!d[12] && r % 3 == 0)
          srcP[c] = srcP[c] & 20'h0ffff;
        wr(6'(c * 8), srcP[c][15:0]);
        wr(6'(c * 8 + 1), {12'habc, srcP[c][19:16]});
        wr(6'(c * 8 + 2), dstP[c][15:0]);
        wr(6'(c * 8 + 3), {12'h5d3, dstP[c][19:16]});
        wr(6'(c * 8 + 4), d[15:0]);
      end
      prioReg = $urandom % 16 + (r == 5 ? 16 : 0);
      wr(6'h20, prioReg[15:0]);
      waitCycles <= 2'($urandom);
      jitter <= 1'h1;
      pin <= 4'($urandom);
      inner <= 5'($urandom);
      repeat (150) @(posedge clk_sys);
    end
    complete_run();
  end
endmodule
`default_nettype wire
